// *** atsc_pkg.sv ***
// Constants and types for the scheduled transmit channel
`default_nettype none
package atsc_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   // Window selects on address bits 11:10, then byte addresses of the register window
   localparam logic [1:0] WIN_CMD = 2'h0;
   localparam logic [1:0] WIN_MSG = 2'h1;
   localparam logic [1:0] WIN_REG = 2'h2;
   localparam logic [ADDR_W-1:0] OFS_ASYNC = 12'h800;
   localparam logic [ADDR_W-1:0] OFS_TRIG = 12'h804;
   localparam logic [ADDR_W-1:0] OFS_PAUSE = 12'h808;
   localparam logic [ADDR_W-1:0] OFS_STOP = 12'h80c;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h810;
   localparam logic [ADDR_W-1:0] OFS_MRST = 12'h814;
   localparam logic [ADDR_W-1:0] OFS_STAT = 12'h818;
   localparam logic [31:0] CTRL_RST = 32'h0;
   localparam logic [31:0] CTRL_MASK = 32'h000f_0dff;
   // Control register fields
   localparam int CB_HOLD = 19;
   localparam int CB_MCLR = 18;
   localparam int CB_RXCLR = 17;
   localparam int CB_TXCLR = 16;
   localparam int CB_RXCIRC = 11;
   localparam int CB_NOSTORE = 10;
   localparam int CB_TSEN = 8;
   localparam int CB_MATCH = 7;
   localparam int CB_PARDIS = 6;
   localparam int CB_SPEED = 5;
   localparam int CB_MODE_HI = 4;
   localparam int CB_MODE_LO = 3;
   localparam int CB_TXEN = 2;
   localparam int CB_RXMODE = 1;
   localparam int CB_RXEN = 0;
   localparam logic [1:0] MODE_IMM = 2'h0;
   localparam logic [1:0] MODE_SCHED = 2'h1;
   localparam logic [1:0] MODE_TRIG = 2'h2;
   // Status register fields
   localparam int SB_SCHINT = 10;
   localparam int SB_ASYNC = 11;
   localparam int SB_RUN = 12;
   localparam int SB_PAUSE = 13;
   localparam int MRST_BIT = 0;
   // Schedule command fields
   localparam int OP_HI = 15;
   localparam int OP_LO = 12;
   localparam logic [3:0] OP_STOP = 4'h0;
   localparam logic [3:0] OP_MSG = 4'h1;
   localparam logic [3:0] OP_GAP = 4'h2;
   localparam logic [3:0] OP_FGAP = 4'h3;
   localparam logic [3:0] OP_PAUSE = 4'h4;
   localparam logic [3:0] OP_SCHINT = 4'h5;
   localparam logic [3:0] OP_JUMP = 4'h6;
   // Gap and async word placement, in bit times
   localparam logic [31:0] ASYNC_MIN_GAP = 32'd40;
   localparam logic [31:0] ASYNC_PRE = 32'd4;
   localparam logic [31:0] ASYNC_END = 32'd36;
   localparam logic [31:0] FIFO_GAP = 32'd4;
   localparam logic [15:0] RX_IDLE_BITS = 16'd4;
   // Timing
   localparam int CLK_NS = 10;
   localparam int HI_BIT_NS = 10000;
   localparam int LO_BIT_NS = 80000;
   localparam int MCLR_NS = 100000;
   localparam int HI_BIT_CYC = HI_BIT_NS / CLK_NS;
   localparam int LO_BIT_CYC_DEF = LO_BIT_NS / CLK_NS;
   localparam int MCLR_CYC_DEF = MCLR_NS / CLK_NS;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_FETCH = 3'h1,
      ST_SEND = 3'h3,
      ST_GAP = 3'h2,
      ST_PAUSE = 3'h6
   } atsc_state_e;
endpackage
`default_nettype wire

// *** atsc_top.sv ***
// Scheduled transmit engine, channel control and APB register file for one channel
`default_nettype none
module atsc_top
   import atsc_pkg::*;
#(
   parameter int LO_BIT_CYC = atsc_pkg::LO_BIT_CYC_DEF,
   parameter int MCLR_CYC = atsc_pkg::MCLR_CYC_DEF,
   parameter int CHAN_IDX = 0
)(
   input wire logic REF_CLK_IN,
   input wire logic RST_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [atsc_pkg::ADDR_W-1:0] PADDR_IN,
   input wire logic [atsc_pkg::DATA_W-1:0] PWDATA_IN,
   output logic [atsc_pkg::DATA_W-1:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   input wire logic TXF_VALID_IN,
   input wire logic [31:0] TXF_DATA_IN,
   output logic TXF_POP_OUT,
   input wire logic RX_LINE_IDLE_IN,
   output logic TX_HI_OUT,
   output logic TX_LO_OUT,
   output logic TX_FIFO_CLEAR_OUT,
   output logic RX_FIFO_CLEAR_OUT,
   output logic MATCH_CLEAR_OUT,
   output logic RX_DECODE_EN_OUT,
   output logic RX_CIRCULAR_OUT,
   output logic RX_DROP_PERR_OUT,
   output logic RX_STAMP_EN_OUT,
   output logic RX_FILTER_EN_OUT,
   output logic RX_PARITY_CHECK_OUT,
   output logic RX_MAILBOX_OUT,
   output logic CHAN_HOLD_OUT
);
   import atsc_pkg::*;

   logic [31:0] cmd_mem [256];
   logic [31:0] msg_mem [256];
   logic [31:0] ctrl_q, ctrl_d, async_q, async_d, rdata_q, rdata_d;
   logic unit_rst_q, unit_rst_d, pend_q, pend_d, schint_q, schint_d;
   logic pause_req_q, pause_req_d, stop_req_q, stop_req_d, prev_msg_q, prev_msg_d;
   logic asel_q, asel_d, hi_q, hi_d, lo_q, lo_d, mclr_q, mclr_d;
   logic [15:0] mcnt_q, mcnt_d, rx_cnt_q, rx_cnt_d;
   logic rx_ok_q, rx_ok_d;
   atsc_state_e st_q, st_d;
   logic [7:0] pc_q, pc_d;
   logic [4:0] bidx_q, bidx_d;
   logic [13:0] tick_q, tick_d, bit_cyc;
   logic [31:0] gpos_q, gpos_d, glen_q, glen_d, word_q, word_d;

   logic acc, wr, setup, is_cmd, is_msg, map_ok, eng_rst, bit_tick;
   logic wr_trig, wr_pause, wr_stop, wr_ctrl;
   logic [1:0] mode;
   logic [31:0] cmd, opnd_word;
   logic [3:0] op;
   logic drive_on, drive_bit, hold_ok;

   assign acc = PSEL_IN & PENABLE_IN;
   assign setup = PSEL_IN & ~PENABLE_IN;
   assign is_cmd = PADDR_IN[11:10] == WIN_CMD;
   assign is_msg = PADDR_IN[11:10] == WIN_MSG;
   assign map_ok = PADDR_IN[1:0] == 2'h0 && (is_cmd || is_msg
      || (PADDR_IN[11:10] == WIN_REG && PADDR_IN <= OFS_STAT));
   assign wr = acc & PWRITE_IN & map_ok;
   assign wr_trig = wr && PADDR_IN == OFS_TRIG && PWDATA_IN[CHAN_IDX];
   assign wr_pause = wr && PADDR_IN == OFS_PAUSE && PWDATA_IN[CHAN_IDX];
   assign wr_stop = wr && PADDR_IN == OFS_STOP && PWDATA_IN[CHAN_IDX];
   assign wr_ctrl = wr && PADDR_IN == OFS_CTRL;
   // Zero wait states: read data is captured in the setup cycle
   assign PREADY_OUT = 1'b1;
   assign PSLVERR_OUT = acc & ~map_ok;
   assign PRDATA_OUT = rdata_q;

   assign eng_rst = ctrl_q[CB_HOLD] | unit_rst_q;
   assign mode = ctrl_q[CB_MODE_HI:CB_MODE_LO];
   assign bit_cyc = ctrl_q[CB_SPEED] ? 14'(HI_BIT_CYC) : 14'(LO_BIT_CYC);
   assign bit_tick = tick_q == bit_cyc - 14'h1;
   assign cmd = cmd_mem[pc_q];
   assign op = cmd[OP_HI:OP_LO];
   assign opnd_word = msg_mem[cmd[7:0]];
   // Without a trailing gap the halt comes straight after the word
   assign hold_ok = !prev_msg_q || (op != OP_GAP && op != OP_FGAP);

   // Memories keep contents across every reset
   always_ff @(posedge REF_CLK_IN)
   begin
      if (wr && is_cmd)
      begin
         cmd_mem[PADDR_IN[9:2]] <= PWDATA_IN;
      end
      if (wr && is_msg)
      begin
         msg_mem[PADDR_IN[9:2]] <= PWDATA_IN;
      end
   end

   function automatic logic [31:0] with_par(input logic [31:0] w, input logic dis);
      with_par = dis ? w : {~^w[30:0], w[30:0]};
   endfunction

   always_comb
   begin
      rdata_d = rdata_q;
      if (setup)
      begin
         rdata_d = 32'h0;
         if (is_cmd)
         begin
            rdata_d = cmd_mem[PADDR_IN[9:2]];
         end
         else if (is_msg)
         begin
            rdata_d = msg_mem[PADDR_IN[9:2]];
         end
         else if (PADDR_IN == OFS_ASYNC)
         begin
            rdata_d = async_q;
         end
         else if (PADDR_IN == OFS_CTRL)
         begin
            rdata_d = ctrl_q;
         end
         else if (PADDR_IN == OFS_STAT)
         begin
            rdata_d = 32'h0;
            rdata_d[SB_SCHINT] = schint_q;
            rdata_d[SB_ASYNC] = pend_q;
            rdata_d[SB_RUN] = st_q != ST_IDLE && st_q != ST_PAUSE;
            rdata_d[SB_PAUSE] = st_q == ST_PAUSE;
         end
      end
   end

   // Control, module reset and match-clear timer
   always_comb
   begin
      ctrl_d = ctrl_q;
      unit_rst_d = unit_rst_q;
      async_d = async_q;
      mclr_d = mclr_q;
      mcnt_d = mcnt_q;
      if (wr && PADDR_IN == OFS_MRST)
      begin
         unit_rst_d = PWDATA_IN[MRST_BIT];
      end
      if (wr && PADDR_IN == OFS_ASYNC)
      begin
         async_d = PWDATA_IN;
      end
      if (wr_ctrl)
      begin
         ctrl_d = PWDATA_IN & CTRL_MASK;
      end
      if (ctrl_q[CB_MCLR] && !mclr_q)
      begin
         // Without filtering there is nothing to clear
         mclr_d = ctrl_q[CB_MATCH];
         mcnt_d = 16'h0;
         ctrl_d[CB_MCLR] = 1'b0;
      end
      if (mclr_q)
      begin
         mcnt_d = mcnt_q + 16'h1;
         if (mcnt_q == 16'(MCLR_CYC - 1))
         begin
            mclr_d = 1'b0;
         end
      end
      if (unit_rst_q)
      begin
         ctrl_d = CTRL_RST;
         async_d = 32'h0;
         mclr_d = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         ctrl_q <= CTRL_RST;
         unit_rst_q <= 1'b0;
         async_q <= 32'h0;
         mclr_q <= 1'b0;
         mcnt_q <= 16'h0;
         rdata_q <= 32'h0;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         unit_rst_q <= unit_rst_d;
         async_q <= async_d;
         mclr_q <= mclr_d;
         mcnt_q <= mcnt_d;
         rdata_q <= rdata_d;
      end
   end

   // FIFO clears act on the falling edge of the host's clear bit
   assign TX_FIFO_CLEAR_OUT = eng_rst | (wr_ctrl & ctrl_q[CB_TXCLR] & ~PWDATA_IN[CB_TXCLR]);
   assign RX_FIFO_CLEAR_OUT = eng_rst | (wr_ctrl & ctrl_q[CB_RXCLR] & ~PWDATA_IN[CB_RXCLR]);
   assign MATCH_CLEAR_OUT = mclr_q;
   assign CHAN_HOLD_OUT = eng_rst;
   assign RX_CIRCULAR_OUT = ctrl_q[CB_RXCIRC];
   assign RX_DROP_PERR_OUT = ctrl_q[CB_NOSTORE] & ~ctrl_q[CB_PARDIS];
   assign RX_STAMP_EN_OUT = ctrl_q[CB_TSEN];
   assign RX_FILTER_EN_OUT = ctrl_q[CB_MATCH];
   assign RX_PARITY_CHECK_OUT = ~ctrl_q[CB_PARDIS];
   assign RX_MAILBOX_OUT = ctrl_q[CB_RXMODE];
   assign RX_DECODE_EN_OUT = rx_ok_q;

   // Receiver arming: four whole idle bit times after enable
   always_comb
   begin
      rx_cnt_d = rx_cnt_q;
      rx_ok_d = rx_ok_q;
      if (!ctrl_q[CB_RXEN] || eng_rst)
      begin
         rx_cnt_d = 16'h0;
         rx_ok_d = 1'b0;
      end
      else if (!rx_ok_q)
      begin
         rx_cnt_d = RX_LINE_IDLE_IN ? rx_cnt_q + 16'h1 : 16'h0;
         if (RX_LINE_IDLE_IN && rx_cnt_q == 16'(RX_IDLE_BITS * 16'(bit_cyc) - 16'h1))
         begin
            rx_ok_d = 1'b1;
         end
      end
   end

   // Line driver: return-to-zero, first half carries the bit
   always_comb
   begin
      drive_on = 1'b0;
      drive_bit = 1'b0;
      if (st_q == ST_SEND)
      begin
         drive_on = 1'b1;
         drive_bit = word_q[bidx_q];
      end
      else if (st_q == ST_GAP && asel_q && gpos_q >= ASYNC_PRE && gpos_q < ASYNC_END)
      begin
         drive_on = 1'b1;
         drive_bit = word_q[5'(gpos_q - ASYNC_PRE)];
      end
      hi_d = !eng_rst && drive_on && tick_q < (bit_cyc >> 1) && drive_bit;
      lo_d = !eng_rst && drive_on && tick_q < (bit_cyc >> 1) && !drive_bit;
   end

   // Transmit sequencer
   always_comb
   begin
      st_d = st_q;
      pc_d = pc_q;
      bidx_d = bidx_q;
      tick_d = bit_tick ? 14'h0 : tick_q + 14'h1;
      gpos_d = gpos_q;
      glen_d = glen_q;
      word_d = word_q;
      asel_d = asel_q;
      prev_msg_d = prev_msg_q;
      pend_d = pend_q;
      schint_d = schint_q;
      pause_req_d = pause_req_q | (wr_pause & (mode == MODE_SCHED || mode == MODE_TRIG));
      stop_req_d = stop_req_q | wr_stop;
      TXF_POP_OUT = 1'b0;
      if (wr && PADDR_IN == OFS_STAT && PWDATA_IN[SB_SCHINT])
      begin
         schint_d = 1'b0;
      end
      unique case (st_q)
         ST_IDLE:
         begin
            stop_req_d = 1'b0;
            pause_req_d = 1'b0;
            if (wr_stop)
            begin
               pend_d = 1'b0;
            end
            if (ctrl_q[CB_TXEN] && (mode == MODE_IMM || wr_trig))
            begin
               st_d = ST_FETCH;
               pc_d = 8'h0;
               prev_msg_d = 1'b0;
            end
         end
         ST_PAUSE:
         begin
            pause_req_d = 1'b0;
            if (stop_req_q)
            begin
               st_d = ST_IDLE;
               pend_d = 1'b0;
            end
            else if (wr_trig)
            begin
               st_d = ST_FETCH;
               prev_msg_d = 1'b0;
            end
         end
         ST_FETCH:
         begin
            tick_d = 14'h0;
            gpos_d = 32'h0;
            bidx_d = 5'h0;
            asel_d = 1'b0;
            if ((stop_req_q && hold_ok) || !ctrl_q[CB_TXEN] || mode == 2'h3)
            begin
               st_d = ST_IDLE;
               pend_d = 1'b0;
            end
            else if (pause_req_q && hold_ok)
            begin
               st_d = ST_PAUSE;
            end
            else if (mode != MODE_SCHED)
            begin
               if (TXF_VALID_IN)
               begin
                  TXF_POP_OUT = 1'b1;
                  word_d = with_par(TXF_DATA_IN, ctrl_q[CB_PARDIS]);
                  st_d = ST_SEND;
               end
               else if (mode == MODE_TRIG)
               begin
                  st_d = ST_IDLE;
               end
            end
            else
            begin
               prev_msg_d = 1'b0;
               pc_d = pc_q + 8'h1;
               unique case (op)
                  OP_STOP:
                  begin
                     st_d = ST_IDLE;
                     pend_d = 1'b0;
                  end
                  OP_MSG:
                  begin
                     word_d = with_par(opnd_word, ctrl_q[CB_PARDIS]);
                     st_d = ST_SEND;
                  end
                  OP_GAP, OP_FGAP:
                  begin
                     glen_d = opnd_word;
                     asel_d = pend_q && op == OP_GAP && opnd_word >= ASYNC_MIN_GAP;
                     word_d = with_par(async_q, ctrl_q[CB_PARDIS]);
                     st_d = opnd_word == 32'h0 ? ST_FETCH : ST_GAP;
                  end
                  OP_PAUSE:
                  begin
                     st_d = ST_PAUSE;
                  end
                  OP_SCHINT:
                  begin
                     schint_d = 1'b1;
                  end
                  OP_JUMP:
                  begin
                     pc_d = cmd[7:0];
                  end
                  default:
                  begin
                     st_d = ST_FETCH;
                  end
               endcase
            end
         end
         ST_SEND:
         begin
            if (bit_tick)
            begin
               bidx_d = bidx_q + 5'h1;
               if (bidx_q == 5'h1f)
               begin
                  prev_msg_d = mode == MODE_SCHED;
                  glen_d = FIFO_GAP;
                  st_d = mode == MODE_SCHED ? ST_FETCH : ST_GAP;
               end
            end
         end
         ST_GAP:
         begin
            if (bit_tick)
            begin
               gpos_d = gpos_q + 32'h1;
               if (asel_q && gpos_q == ASYNC_END - 32'h1)
               begin
                  pend_d = 1'b0;
                  asel_d = 1'b0;
               end
               if (gpos_d == glen_q)
               begin
                  st_d = ST_FETCH;
               end
            end
         end
         default:
         begin
            st_d = ST_IDLE;
         end
      endcase
      if (wr && PADDR_IN == OFS_ASYNC)
      begin
         pend_d = 1'b1;
      end
      if (eng_rst)
      begin
         st_d = ST_IDLE;
         pend_d = 1'b0;
         schint_d = 1'b0;
         pause_req_d = 1'b0;
         stop_req_d = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         st_q <= ST_IDLE;
         pc_q <= 8'h0;
         bidx_q <= 5'h0;
         tick_q <= 14'h0;
         gpos_q <= 32'h0;
         glen_q <= 32'h0;
         word_q <= 32'h0;
         asel_q <= 1'b0;
         prev_msg_q <= 1'b0;
         pend_q <= 1'b0;
         schint_q <= 1'b0;
         pause_req_q <= 1'b0;
         stop_req_q <= 1'b0;
         hi_q <= 1'b0;
         lo_q <= 1'b0;
         rx_cnt_q <= 16'h0;
         rx_ok_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         pc_q <= pc_d;
         bidx_q <= bidx_d;
         tick_q <= tick_d;
         gpos_q <= gpos_d;
         glen_q <= glen_d;
         word_q <= word_d;
         asel_q <= asel_d;
         prev_msg_q <= prev_msg_d;
         pend_q <= pend_d;
         schint_q <= schint_d;
         pause_req_q <= pause_req_d;
         stop_req_q <= stop_req_d;
         hi_q <= hi_d;
         lo_q <= lo_d;
         rx_cnt_q <= rx_cnt_d;
         rx_ok_q <= rx_ok_d;
      end
   end

   assign TX_HI_OUT = hi_q;
   assign TX_LO_OUT = lo_q;
endmodule
`default_nettype wire

// *** atsc_assertions.sv ***
// Port-level checks for the scheduled transmit channel
`default_nettype none
module atsc_assertions
   import atsc_pkg::*;
#(
   parameter int LO_BIT_CYC = 8000,
   parameter int MCLR_CYC = 10000
)(
   input wire logic REF_CLK_IN,
   input wire logic RST_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [atsc_pkg::ADDR_W-1:0] PADDR_IN,
   input wire logic [atsc_pkg::DATA_W-1:0] PWDATA_IN,
   input wire logic RX_LINE_IDLE_IN,
   input wire logic TX_HI_OUT,
   input wire logic TX_LO_OUT,
   input wire logic TX_FIFO_CLEAR_OUT,
   input wire logic RX_FIFO_CLEAR_OUT,
   input wire logic MATCH_CLEAR_OUT,
   input wire logic RX_DECODE_EN_OUT,
   input wire logic RX_DROP_PERR_OUT,
   input wire logic RX_PARITY_CHECK_OUT,
   input wire logic CHAN_HOLD_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   // Slack of two for the registered arm output
   localparam int ARM_MIN = 4 * ((LO_BIT_CYC < HI_BIT_CYC) ? LO_BIT_CYC : HI_BIT_CYC) - 2;
   logic [31:0] mclr_cnt_q;
   logic [31:0] idle_cnt_q;
   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         mclr_cnt_q <= 32'h0;
         idle_cnt_q <= 32'h0;
      end
      else
      begin
         mclr_cnt_q <= MATCH_CLEAR_OUT ? mclr_cnt_q + 32'h1 : 32'h0;
         idle_cnt_q <= RX_LINE_IDLE_IN ? idle_cnt_q + 32'h1 : 32'h0;
      end
   end
   default clocking cb @(posedge REF_CLK_IN);
   endclocking
   default disable iff (RST_IN);
   sequence wr_s(logic [11:0] a);
      PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == a;
   endsequence
   sequence held_s;
      CHAN_HOLD_OUT [*3];
   endsequence
   hold_follow_a: assert property (wr_s(OFS_CTRL) ##0 PWDATA_IN[CB_HOLD] |=> CHAN_HOLD_OUT)
      else $error("hold bit write did not hold channel");
   hold_flush_a: assert property (CHAN_HOLD_OUT |-> TX_FIFO_CLEAR_OUT && RX_FIFO_CLEAR_OUT)
      else $error("fifos not flushed while held");
   hold_quiet_a: assert property (held_s |-> !TX_HI_OUT && !TX_LO_OUT)
      else $error("line driven while held");
   mrst_hold_a: assert property (wr_s(OFS_MRST) ##0 PWDATA_IN[MRST_BIT] |=> CHAN_HOLD_OUT)
      else $error("module reset did not hold channel");
   mclr_len_a: assert property ($fell(MATCH_CLEAR_OUT) |-> mclr_cnt_q == MCLR_CYC)
      else $error("match clear length wrong");
   mclr_go_a: assert property (wr_s(OFS_CTRL) ##0 (PWDATA_IN[CB_MCLR] && PWDATA_IN[CB_MATCH] && !PWDATA_IN[CB_HOLD]) |-> ##[1:3] MATCH_CLEAR_OUT)
      else $error("match clear not started");
   arm_wait_a: assert property ($rose(RX_DECODE_EN_OUT) |-> idle_cnt_q >= ARM_MIN)
      else $error("receiver armed without idle line");
   perr_dep_a: assert property (RX_DROP_PERR_OUT |-> RX_PARITY_CHECK_OUT)
      else $error("error drop active without parity");
endmodule
bind atsc_top atsc_assertions #(.LO_BIT_CYC(LO_BIT_CYC), .MCLR_CYC(MCLR_CYC)) u_atsc_chk (
   .REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
   .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
   .RX_LINE_IDLE_IN(RX_LINE_IDLE_IN), .TX_HI_OUT(TX_HI_OUT), .TX_LO_OUT(TX_LO_OUT),
   .TX_FIFO_CLEAR_OUT(TX_FIFO_CLEAR_OUT), .RX_FIFO_CLEAR_OUT(RX_FIFO_CLEAR_OUT),
   .MATCH_CLEAR_OUT(MATCH_CLEAR_OUT), .RX_DECODE_EN_OUT(RX_DECODE_EN_OUT),
   .RX_DROP_PERR_OUT(RX_DROP_PERR_OUT), .RX_PARITY_CHECK_OUT(RX_PARITY_CHECK_OUT),
   .CHAN_HOLD_OUT(CHAN_HOLD_OUT));
`default_nettype wire

// *** atsc_line_rx.sv ***
// Line receiver model: decodes return-to-zero words, bit 0 first
`default_nettype none
module atsc_line_rx (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic one_in,
   input wire logic zero_in,
   output logic [31:0] word_out,
   output logic [7:0] count_out,
   output logic [31:0] period_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic one_q, zero_q, edge_w;
   logic [31:0] shift_q, tick_q;
   logic [4:0] nbit_q;
   assign edge_w = (one_in && !one_q) || (zero_in && !zero_q);
   // No resync on long nulls: words must never be cut short
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         one_q <= 1'b0;
         zero_q <= 1'b0;
         shift_q <= 32'h0;
         tick_q <= 32'h0;
         nbit_q <= 5'h0;
         word_out <= 32'h0;
         count_out <= 8'h0;
         period_out <= 32'h0;
      end
      else
      begin
         one_q <= one_in;
         zero_q <= zero_in;
         tick_q <= edge_w ? 32'h1 : tick_q + 32'h1;
         if (edge_w)
         begin
            period_out <= tick_q;
            shift_q <= {one_in, shift_q[31:1]};
            nbit_q <= nbit_q + 5'h1;
            if (nbit_q == 5'h1f)
            begin
               word_out <= {one_in, shift_q[31:1]};
               count_out <= count_out + 8'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** atsc_top_tb.sv ***
// Self-checking bench for the scheduled transmit channel
`default_nettype none
module atsc_top_tb;
   import atsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic rx_idle = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, lw, per, rd, m0;
   logic pready, pslverr, tx_hi, tx_lo, hold, circ, drop, stamp, filt, mbox, pchk, dec_en, se;
   logic [7:0] wc;
   int err_count = 0;
   int check_count = 0;
   logic txclr, rxclr, pop;
   logic [1:0] cl;
   logic fv = 1'b0;
   logic [31:0] fd = 32'h0;
   int pop_count = 0;
   atsc_top #(.LO_BIT_CYC(40), .MCLR_CYC(8)) DUT (
      .REF_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
      .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .TXF_VALID_IN(fv), .TXF_DATA_IN(fd), .TXF_POP_OUT(pop),
      .RX_LINE_IDLE_IN(rx_idle), .TX_HI_OUT(tx_hi), .TX_LO_OUT(tx_lo),
      .TX_FIFO_CLEAR_OUT(txclr), .RX_FIFO_CLEAR_OUT(rxclr), .MATCH_CLEAR_OUT(),
      .RX_DECODE_EN_OUT(dec_en), .RX_CIRCULAR_OUT(circ), .RX_DROP_PERR_OUT(drop),
      .RX_STAMP_EN_OUT(stamp), .RX_FILTER_EN_OUT(filt), .RX_PARITY_CHECK_OUT(pchk),
      .RX_MAILBOX_OUT(mbox), .CHAN_HOLD_OUT(hold));
   atsc_line_rx u_rx (.clk_in(clk), .rst_in(rst), .one_in(tx_hi), .zero_in(tx_lo),
      .word_out(lw), .count_out(wc), .period_out(per));
   initial
   begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
      if (pop)
         pop_count <= pop_count + 1;
   task automatic end_sim();
      if (err_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e)
      begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   function automatic logic [31:0] par(input logic [31:0] d);
      return {~^d[30:0], d[30:0]};
   endfunction
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         err_count++;
         end_sim();
      end
      rd = prdata;
      se = pslverr;
      cl = {txclr, rxclr};
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdr(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic wait_stat(input int b, input logic v);
      int n;
      for (n = 0; n < 3000; n++)
      begin
         rdr(OFS_STAT);
         if (rd[b] === v)
            break;
      end
      if (n >= 3000)
      begin
         err_count++;
         end_sim();
      end
   endtask
   task automatic t_regs();
      int n;
      rdr(OFS_CTRL);
      chk(rd, CTRL_RST);
      rdr(OFS_TRIG);
      chk(rd, 32'h0);
      rdr(12'h81c);
      chk({rd[30:0], se}, 32'h1);
      rdr(12'h813);
      chk({31'h0, se}, 32'h1);
      wr(OFS_CTRL, 32'h0008_0d81);
      chk({hold, circ, drop, stamp, filt, mbox, pchk}, 7'h7d);
      wr(OFS_CTRL, 32'h0004_0dc1);
      chk(dec_en, 1'b0);
      rx_idle <= 1'b1;
      for (n = 0; n < 300 && dec_en !== 1'b1; n++)
         @(posedge clk);
      chk({dec_en, n >= 150}, 2'h3);
      rdr(OFS_CTRL);
      chk({rd[29:0], drop, pchk}, 32'h0000_3704);
      wr(OFS_CTRL, 32'h0003_0dc1);
      chk(cl, 2'h0);
      wr(OFS_CTRL, 32'h0000_0dc1);
      chk(cl, 2'h3);
   endtask
   task automatic t_sched(input logic [31:0] c, input logic [31:0] d, input logic [31:0] e);
      logic [7:0] b;
      wr(OFS_STAT, 32'h0000_0400);
      rdr(OFS_STAT);
      chk(rd[SB_SCHINT], 1'b0);
      wr(12'h400, d);
      wr(12'h404, 32'h4);
      wr(12'h000, 32'h1000);
      wr(12'h004, 32'h5000);
      wr(12'h008, 32'h7000);
      wr(12'h00c, 32'h8000);
      wr(12'h010, 32'h6006);
      wr(12'h014, 32'h1001);
      wr(12'h018, 32'h3001);
      wr(12'h01c, 32'h0000);
      wr(OFS_CTRL, c);
      b = wc;
      wr(OFS_TRIG, 32'h1);
      wait_stat(SB_RUN, 1'b0);
      chk(wc - b, 8'h1);
      chk(lw, e);
      chk({per[30:0], rd[SB_SCHINT]}, 32'h51);
      m0 = d;
   endtask
   task automatic t_async();
      logic [7:0] b;
      wr(OFS_CTRL, 32'h0c);
      wr(12'h408, 32'h28);
      wr(12'h000, 32'h3002);
      wr(12'h004, 32'h0000);
      b = wc;
      wr(OFS_ASYNC, 32'h0abc_0123);
      rdr(OFS_STAT);
      chk(rd[SB_ASYNC], 1'b1);
      wr(OFS_TRIG, 32'h1);
      wait_stat(SB_RUN, 1'b0);
      chk({wc - b, rd[SB_ASYNC]}, 9'h0);
      wr(OFS_ASYNC, 32'h0abc_0123);
      wr(OFS_STOP, 32'h1);
      rdr(OFS_STAT);
      chk(rd[SB_ASYNC], 1'b0);
      wr(12'h000, 32'h2002);
      wr(OFS_ASYNC, 32'h0abc_0123);
      wr(OFS_TRIG, 32'h1);
      wait_stat(SB_RUN, 1'b0);
      chk({wc - b, rd[SB_ASYNC]}, 9'h2);
      chk(lw, par(32'h0abc_0123));
   endtask
   task automatic t_halt();
      logic [7:0] b;
      wr(12'h000, 32'h1000);
      wr(12'h004, 32'h2001);
      wr(12'h008, 32'h4000);
      wr(12'h00c, 32'h1000);
      wr(12'h010, 32'h2001);
      wr(12'h014, 32'h6000);
      b = wc;
      wr(OFS_TRIG, 32'h1);
      wait_stat(SB_PAUSE, 1'b1);
      chk(wc - b, 8'h1);
      wr(OFS_TRIG, 32'h1);
      wr(OFS_PAUSE, 32'h1);
      wait_stat(SB_PAUSE, 1'b1);
      chk(wc - b, 8'h2);
      wr(OFS_STOP, 32'h1);
      rdr(OFS_STAT);
      chk(rd[SB_PAUSE:SB_RUN], 2'h0);
      wr(OFS_TRIG, 32'h1);
      wr(OFS_STOP, 32'h1);
      wait_stat(SB_RUN, 1'b0);
      chk(wc - b, 8'h3);
      wr(OFS_CTRL, 32'h1c);
      wr(OFS_TRIG, 32'h1);
      rdr(OFS_STAT);
      chk({wc - b, rd[SB_RUN]}, 9'h6);
   endtask
   task automatic t_fifo();
      logic [7:0] b;
      wr(OFS_CTRL, 32'h14);
      b = wc;
      fd <= 32'h1357_9bdf;
      fv <= 1'b1;
      wr(OFS_TRIG, 32'h1);
      fv <= 1'b0;
      wait_stat(SB_RUN, 1'b0);
      chk(wc - b, 8'h1);
      chk(lw, par(32'h1357_9bdf));
      chk(pop_count, 32'h1);
   endtask
   task automatic t_mrst();
      logic [7:0] b;
      wr(OFS_MRST, 32'h1);
      rdr(OFS_CTRL);
      chk({rd[30:0], hold}, 32'h1);
      wr(OFS_MRST, 32'h0);
      wr(OFS_CTRL, 32'h0c);
      b = wc;
      wr(OFS_TRIG, 32'h1);
      wr(OFS_STOP, 32'h1);
      wait_stat(SB_RUN, 1'b0);
      chk(wc - b, 8'h1);
      chk(lw, par(m0));
   endtask
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_sched(32'h0c, 32'h1234_5678, par(32'h1234_5678));
      t_sched(32'h4c, 32'h8000_0001, 32'h8000_0001);
      t_async();
      t_halt();
      t_fifo();
      t_mrst();
      end_sim();
   end
endmodule
`default_nettype wire
